/* include/rca_core_defines.vh */
// constants for the eight-bit execution core: phases, sfr map, fields
// assumes inclusion by its bare name from the core module
`ifndef RCA_CORE_DEFINES_VH
`define RCA_CORE_DEFINES_VH
// ------------------------------------------------------------
// phase counter codes
// ------------------------------------------------------------
`define RCA_PH1        2'h0
`define RCA_PH2        2'h1
`define RCA_PH3        2'h2
`define RCA_PH4        2'h3
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RCA_RST_VEC    13'h0000
`define RCA_NOP        14'h0000
`define RCA_STAT_RST   8'h18
// ------------------------------------------------------------
// special registers inside data memory
// ------------------------------------------------------------
`define RCA_A_INDF     7'h00
`define RCA_A_PCL      7'h02
`define RCA_A_STAT     7'h03
`define RCA_A_FSR      7'h04
`define RCA_SB_C       0
`define RCA_SB_DC      1
`define RCA_SB_Z       2
`define RCA_SB_BANK    5
// ------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------
`define RCA_F_CLS      13:12
`define RCA_F_TOP3     13:11
`define RCA_F_OP       11:8
`define RCA_F_BOP      11:10
`define RCA_F_BIT      9:7
`define RCA_F_D        7
`define RCA_F_REG      6:0
`define RCA_F_LIT      7:0
`define RCA_F_JMP      10:0
`define RCA_F_PCH      12:8
`define RCA_F_PCHJ     12:11
// ------------------------------------------------------------
// instruction classes and opcodes
// ------------------------------------------------------------
`define RCA_C_BYTE     2'h0
`define RCA_C_BIT      2'h1
`define RCA_C_LIT      2'h3
`define RCA_C_GOTO     3'h5
`define RCA_O_MOVWF    4'h0
`define RCA_O_CLR      4'h1
`define RCA_O_SUB      4'h2
`define RCA_O_DEC      4'h3
`define RCA_O_IOR      4'h4
`define RCA_O_AND      4'h5
`define RCA_O_XOR      4'h6
`define RCA_O_ADD      4'h7
`define RCA_O_MOVF     4'h8
`define RCA_O_COM      4'h9
`define RCA_O_INC      4'ha
`define RCA_O_DECSZ    4'hb
`define RCA_O_RR       4'hc
`define RCA_O_RL       4'hd
`define RCA_O_SWAP     4'he
`define RCA_O_INCSZ    4'hf
`define RCA_B_CLR      2'h0
`define RCA_B_SET      2'h1
`define RCA_B_SKC      2'h2
`define RCA_B_SKS      2'h3
`endif

/* logic/rca_core.v */
// eight-bit execution core: working register, alu, flags, two-stage pipe
// assumes combinational program and data memories answering in the cycle
// Function
// RULE1: eight-bit alu doing add, subtract, shift and logic operations.
// RULE2: arithmetic operands and results are two's complement bytes.
// RULE3: two-operand ops use working register plus file register or literal.
// RULE4: single-operand ops use working register or a file register.
// RULE5: eight-bit working register held in the core, not data-mapped.
// RULE6: carry, half-carry and zero flags in status update per instruction.
// RULE7: subtraction sets carry and half-carry as inverted borrow.
// RULE8: fourteen-bit instruction words, one whole word fetched per cycle.
// RULE9: fetch of next instruction overlaps execution of the current one.
// RULE10: all instructions take one cycle except branches taking longer.
// RULE11: cycle-rate output runs at a quarter of the input clock rate.
// RULE12: low master clear resets the whole core.
// RULE13: special registers including program counter sit in data memory.
// RULE14: clock divided into four non-overlapping phases per cycle.
// RULE15: operand read in phase two, destination written in phase four.
// RULE16: a program counter change flushes the fetched word; two cycles.
// RULE17: zero flag set when result byte is all zeros, else cleared; movwf, rotate, swap, skip, bit and move-literal ops keep it.
`timescale 1ns/1ps
`default_nettype none
`include "rca_core_defines.vh"
module rca_core (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        master_clear_n,
   // program memory bus
   output reg  [12:0] prog_addr,
   input  wire [13:0] prog_data,
   // data memory bus
   output reg  [7:0]  data_addr,
   output reg         data_rd_en,
   input  wire [7:0]  data_rdata,
   output reg         data_wr_en,
   output reg  [7:0]  data_wdata,
   // phase and cycle outputs
   output reg         phase_one,
   output reg         phase_two,
   output reg         phase_three,
   output reg         phase_four,
   output reg         cycle_rate_output,
   // core state
   output reg  [7:0]  w_value,
   output reg  [7:0]  status_value
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg  [1:0]  ph;
   reg  [1:0]  next_ph;
   reg  [13:0] ir;
   reg  [7:0]  fsr;
   reg  [7:0]  opnd;
   reg  [7:0]  res;
   reg  [7:0]  res_st;
   reg         skip_q;
   reg  [7:0]  next_res;
   reg  [7:0]  next_st;
   reg         wr_f;
   reg         wr_w;
   reg         skip;
   reg  [7:0]  src;
   reg  [7:0]  bx;
   reg         sub_op;
   reg  [8:0]  sum;
   reg  [4:0]  nib;
   reg  [7:0]  bmask;
   wire        rst_all;
   wire [1:0]  cls;
   wire [3:0]  op;
   wire [1:0]  bop;
   wire        dst;
   wire [7:0]  lit;
   wire [7:0]  eff;
   wire        sfr_pcl;
   wire        sfr_st;
   wire        sfr_fsr;
   wire        is_int;
   wire        jump;
   reg  [7:0]  sfr_rd;
   integer     i;

   assign rst_all = ~rst_n | ~master_clear_n; // [RULE12]
   assign cls = ir[`RCA_F_CLS];
   assign op  = ir[`RCA_F_OP];
   assign bop = ir[`RCA_F_BOP];
   assign dst = ir[`RCA_F_D];
   assign lit = ir[`RCA_F_LIT];
   assign jump = (ir[`RCA_F_TOP3] == `RCA_C_GOTO);

   // ------------------------------------------------------------
   // operand addressing: direct via bank bit or indirect via fsr
   // ------------------------------------------------------------
   assign eff = (ir[`RCA_F_REG] == `RCA_A_INDF) ? fsr :
                {status_value[`RCA_SB_BANK], ir[`RCA_F_REG]}; // [RULE13]
   assign sfr_pcl = (eff[6:0] == `RCA_A_PCL);
   assign sfr_st  = (eff[6:0] == `RCA_A_STAT);
   assign sfr_fsr = (eff[6:0] == `RCA_A_FSR);
   assign is_int  = sfr_pcl | sfr_st | sfr_fsr;

   always @* begin
      sfr_rd = fsr;
      if (sfr_pcl) begin
         sfr_rd = prog_addr[7:0];
      end
      if (sfr_st) begin
         sfr_rd = status_value;
      end
   end

   // ------------------------------------------------------------
   // alu and decode
   // ------------------------------------------------------------
   always @* begin
      src = (cls == `RCA_C_LIT) ? lit : opnd; // [RULE3] [RULE4]
      sub_op = 1'b0;
      next_res = src;
      next_st = status_value;
      wr_f = 1'b0;
      wr_w = 1'b0;
      skip = 1'b0;
      bmask = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
         bmask[i] = (ir[`RCA_F_BIT] == i[2:0]);
      end
      if ((cls == `RCA_C_BYTE && op == `RCA_O_SUB) ||
          (cls == `RCA_C_LIT && op[3:1] == 3'h6)) begin
         sub_op = 1'b1;
      end
      bx = sub_op ? ~w_value : w_value;
      // two's complement: subtract is src + ~w + 1
      sum = {1'b0, src} + {1'b0, bx} + {8'h00, sub_op}; // [RULE1] [RULE2]
      nib = {1'b0, src[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub_op};
      case (cls)
         `RCA_C_BYTE: begin
            wr_f = dst;
            wr_w = ~dst;
            case (op)
               `RCA_O_MOVWF: begin
                  next_res = w_value;
                  wr_w = 1'b0;
               end
               `RCA_O_CLR:   next_res = 8'h00;
               `RCA_O_SUB:   next_res = sum[7:0];
               `RCA_O_ADD:   next_res = sum[7:0];
               `RCA_O_DEC:   next_res = src - 8'h01;
               `RCA_O_DECSZ: next_res = src - 8'h01;
               `RCA_O_INC:   next_res = src + 8'h01;
               `RCA_O_INCSZ: next_res = src + 8'h01;
               `RCA_O_IOR:   next_res = src | w_value;
               `RCA_O_AND:   next_res = src & w_value;
               `RCA_O_XOR:   next_res = src ^ w_value;
               `RCA_O_COM:   next_res = ~src;
               `RCA_O_RR:    next_res = {status_value[`RCA_SB_C], src[7:1]};
               `RCA_O_RL:    next_res = {src[6:0], status_value[`RCA_SB_C]};
               `RCA_O_SWAP:  next_res = {src[3:0], src[7:4]};
               default:      next_res = src;
            endcase
            if (op == `RCA_O_ADD || op == `RCA_O_SUB) begin
               next_st[`RCA_SB_C]  = sum[8]; // [RULE6] [RULE7]
               next_st[`RCA_SB_DC] = nib[4]; // [RULE7]
            end
            if (op == `RCA_O_RR) begin
               next_st[`RCA_SB_C] = src[0]; // [RULE6]
            end
            if (op == `RCA_O_RL) begin
               next_st[`RCA_SB_C] = src[7];
            end
            if (op != `RCA_O_MOVWF && op != `RCA_O_RR && op != `RCA_O_RL &&
                op != `RCA_O_SWAP && op != `RCA_O_DECSZ && op != `RCA_O_INCSZ) begin
               next_st[`RCA_SB_Z] = (next_res == 8'h00); // [RULE17]
            end
            if (op == `RCA_O_DECSZ || op == `RCA_O_INCSZ) begin
               skip = (next_res == 8'h00); // [RULE16]
            end
         end
         `RCA_C_BIT: begin
            case (bop)
               `RCA_B_CLR: begin
                  next_res = src & ~bmask;
                  wr_f = 1'b1;
               end
               `RCA_B_SET: begin
                  next_res = src | bmask;
                  wr_f = 1'b1;
               end
               `RCA_B_SKC: skip = ((src & bmask) == 8'h00);
               `RCA_B_SKS: skip = ((src & bmask) != 8'h00);
               default:    skip = 1'b0;
            endcase
         end
         `RCA_C_LIT: begin
            wr_w = 1'b1;
            case (op[3:1])
               3'h0, 3'h1: next_res = lit;
               3'h4:       next_res = lit | w_value;
               3'h5:       next_res = (op[0]) ? (lit & w_value) : (lit ^ w_value);
               3'h6:       next_res = sum[7:0];
               3'h7:       next_res = sum[7:0];
               default:    wr_w = 1'b0;
            endcase
            if (op[3:1] == 3'h4) begin
               next_res = op[0] ? (lit & w_value) : (lit | w_value);
            end
            if (op[3:2] == 2'h3) begin
               next_st[`RCA_SB_C]  = sum[8]; // [RULE7]
               next_st[`RCA_SB_DC] = nib[4];
            end
            if (op[3:2] != 2'h0 && wr_w) begin
               next_st[`RCA_SB_Z] = (next_res == 8'h00); // [RULE17]
            end
         end
         default: begin
            wr_f = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // phase sequencer and cycle-rate output
   // ------------------------------------------------------------
   always @* begin
      next_ph = ph + 2'h1; // [RULE14]
   end

   always @(posedge sys_clk) begin
      if (rst_all) begin
         ph <= `RCA_PH1;
         phase_one <= 1'b0;
         phase_two <= 1'b0;
         phase_three <= 1'b0;
         phase_four <= 1'b0;
         cycle_rate_output <= 1'b0;
      end else begin
         ph <= next_ph;
         phase_one   <= (next_ph == `RCA_PH1); // [RULE14]
         phase_two   <= (next_ph == `RCA_PH2);
         phase_three <= (next_ph == `RCA_PH3);
         phase_four  <= (next_ph == `RCA_PH4);
         // high in phases one and two: one period per four clocks
         cycle_rate_output <= (next_ph == `RCA_PH1) |
                              (next_ph == `RCA_PH2); // [RULE11]
      end
   end

   // ------------------------------------------------------------
   // fetch and execute pipeline
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst_all) begin
         prog_addr <= `RCA_RST_VEC;
         ir <= `RCA_NOP;
         fsr <= 8'h00;
         opnd <= 8'h00;
         res <= 8'h00;
         res_st <= `RCA_STAT_RST;
         skip_q <= 1'b0;
         w_value <= 8'h00;
         status_value <= `RCA_STAT_RST;
         data_addr <= 8'h00;
         data_rd_en <= 1'b0;
         data_wr_en <= 1'b0;
         data_wdata <= 8'h00;
      end else begin
         data_rd_en <= 1'b0;
         data_wr_en <= 1'b0;
         case (ph)
            `RCA_PH1: begin
               data_addr <= eff;
               data_rd_en <= (cls != `RCA_C_LIT) & ~jump & ~is_int; // [RULE15]
            end
            `RCA_PH2: begin
               opnd <= is_int ? sfr_rd : data_rdata; // [RULE15]
            end
            `RCA_PH3: begin
               res <= next_res;
               res_st <= next_st;
               skip_q <= skip;
               data_wdata <= next_res;
               data_wr_en <= wr_f & ~is_int; // [RULE15]
            end
            `RCA_PH4: begin
               if (wr_w) begin
                  w_value <= res; // [RULE5]
               end
               status_value <= res_st; // [RULE6]
               if (wr_f && sfr_st) begin
                  // flag bits keep the computed value over the written byte
                  status_value <= {res[7:3], res_st[2:0]};
               end
               if (wr_f && sfr_fsr) begin
                  fsr <= res;
               end
               // next word enters the execute stage as this one finishes
               ir <= prog_data; // [RULE8] [RULE9]
               prog_addr <= prog_addr + 13'h0001;
               if (jump) begin
                  prog_addr <= {prog_addr[`RCA_F_PCHJ], ir[`RCA_F_JMP]};
                  ir <= `RCA_NOP; // [RULE10] [RULE16]
               end else if (wr_f && sfr_pcl) begin
                  prog_addr <= {prog_addr[`RCA_F_PCH], res}; // [RULE13]
                  ir <= `RCA_NOP; // [RULE16]
               end else if (skip_q) begin
                  ir <= `RCA_NOP; // [RULE10]
               end
            end
            default: begin
               data_rd_en <= 1'b0;
            end
         endcase
      end
   end
endmodule // rca_core
`default_nettype wire

/* sim/rca_core_checker.sv */
// checker for the execution core: phase, bus and reset timing
// assumes it is bound onto rca_core, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rca_core_checker (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        master_clear_n,
   // buses
   input wire logic [12:0] prog_addr,
   input wire logic [7:0]  data_addr,
   input wire logic        data_rd_en,
   input wire logic        data_wr_en,
   // phases and state
   input wire logic        phase_one,
   input wire logic        phase_two,
   input wire logic        phase_three,
   input wire logic        phase_four,
   input wire logic        cycle_rate_output,
   input wire logic [7:0]  w_value,
   input wire logic [7:0]  status_value
);
   logic up;
   always @(posedge sys_clk) begin
      up <= rst_n & master_clear_n;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !master_clear_n);
   property p_onehot; up |-> $onehot({phase_one, phase_two, phase_three, phase_four}); endproperty
   a_onehot: assert property (p_onehot) else $error("phases not one-hot");
   property p_rotate; phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one; endproperty
   a_rotate: assert property (p_rotate) else $error("phase order broken");
   property p_rate; up |-> cycle_rate_output == (phase_one || phase_two); endproperty
   a_rate: assert property (p_rate) else $error("cycle rate level wrong");
   // the first rise after reset comes in phase two and starts a short high level, so periods count from the second
   property p_period; $past(up) && $rose(cycle_rate_output) |->
      ##2 $fell(cycle_rate_output) ##2 $rose(cycle_rate_output); endproperty
   a_period: assert property (p_period) else $error("cycle rate period wrong");
   property p_rd; data_rd_en |-> phase_two; endproperty
   a_rd: assert property (p_rd) else $error("read outside phase two");
   property p_wr; data_wr_en |-> phase_four && data_addr == $past(data_addr, 2); endproperty
   a_wr: assert property (p_wr) else $error("write timing wrong");
   property p_fetch; up && !$stable(prog_addr) |-> $past(phase_four); endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address moved mid cycle");
   property p_init; up && !$past(up) |-> phase_two && prog_addr == 13'h0000 && w_value == 8'h00 && status_value == 8'h18; endproperty
   a_init: assert property (p_init) else $error("state after reset wrong");
   property p_sfr; data_rd_en |-> !(data_addr[6:0] inside {7'h02, 7'h03, 7'h04}); endproperty
   a_sfr: assert property (p_sfr) else $error("internal register read on bus");
endmodule // rca_core_checker
bind rca_core rca_core_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .master_clear_n(master_clear_n), .prog_addr(prog_addr), .data_addr(data_addr),
   .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .phase_one(phase_one),
   .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four),
   .cycle_rate_output(cycle_rate_output), .w_value(w_value), .status_value(status_value));
`default_nettype wire

/* sim/rca_mem_model.sv */
// program and data memories answering within the cycle
// assumes the bench loads prog through the hierarchy
`timescale 1ns/1ps
`default_nettype none
module rca_mem_model (
   // clock
   input wire logic        sys_clk,
   // program bus
   input wire logic [12:0] prog_addr,
   output logic     [13:0] prog_data,
   // data bus
   input wire logic [7:0]  data_addr,
   input wire logic        data_rd_en,
   output logic     [7:0]  data_rdata,
   input wire logic        data_wr_en,
   input wire logic [7:0]  data_wdata
);
   logic [13:0] prog [0:255];
   logic [7:0]  ram [0:255];
   logic [7:0]  junk = 8'h5a;
   assign prog_data = prog[prog_addr[7:0]];
   // unselected read lines show a changing pattern, never stale data
   assign data_rdata = data_rd_en ? ram[data_addr] : junk;
   always @(posedge sys_clk) begin
      junk <= ~junk + 8'h01;
      if (data_wr_en) ram[data_addr] <= data_wdata;
   end
endmodule // rca_mem_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench: random alu programs, branch flush, two resets
// assumes combinational memories from rca_mem_model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        sys_clk, rst_n, master_clear_n, data_rd_en, data_wr_en;
   logic        phase_one, phase_two, phase_three, phase_four, cycle_rate_output;
   logic [12:0] prog_addr;
   logic [13:0] prog_data;
   logic [7:0]  data_addr, data_rdata, data_wdata, w_value, status_value;
   int          error_cnt, tests_run, wi, n, p;
   logic [15:0] exp_a [0:99];
   logic [31:0] seed;
   logic        c, dc;
   localparam logic [3:0] OPC [0:11] = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'hd, 4'hc,
                                         4'ha, 4'h3, 4'h9, 4'he, 4'h1};
   rca_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .master_clear_n(master_clear_n),
      .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
      .data_rd_en(data_rd_en), .data_rdata(data_rdata), .data_wr_en(data_wr_en),
      .data_wdata(data_wdata), .phase_one(phase_one), .phase_two(phase_two),
      .phase_three(phase_three), .phase_four(phase_four),
      .cycle_rate_output(cycle_rate_output), .w_value(w_value), .status_value(status_value));
   rca_mem_model mem (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
      .data_addr(data_addr), .data_rd_en(data_rd_en), .data_rdata(data_rdata),
      .data_wr_en(data_wr_en), .data_wdata(data_wdata));
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // returns {carry, half carry, zero, result}
   function automatic logic [10:0] alu(input int k, input logic [7:0] a, b, input logic ci, dci);
      logic [7:0] r;
      logic       co, dco;
      co = ci;
      dco = dci;
      case (k)
         0: begin r = a + b; co = ({1'b0, a} + {1'b0, b}) > 9'h0ff;
            dco = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f; end
         1: begin r = a - b; co = a >= b; dco = a[3:0] >= b[3:0]; end
         2: r = a & b;
         3: r = a | b;
         4: r = a ^ b;
         5: begin r = {a[6:0], ci}; co = a[7]; end
         6: begin r = {ci, a[7:1]}; co = a[0]; end
         7: r = a + 8'h01;
         8: r = a - 8'h01;
         9: r = ~a;
         10: r = {a[3:0], a[7:4]};
         default: r = 8'h00;
      endcase
      // rotates and nibble swap leave zero alone; it is always clear on entry here
      return {co, dco, !(k inside {5, 6, 10}) && (r == 8'h00), r};
   endfunction
   task chk(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task put(input logic [13:0] w);
      mem.prog[p] = w;
      p++;
   endtask
   task want(input logic [15:0] e);
      exp_a[n] = e;
      n++;
   endtask
   // each test: load f, load w, operate, store result and status
   task build;
      int          t, k;
      logic [7:0]  a, b;
      logic [10:0] f;
      for (t = 0; t < 24; t++) begin
         seed = xs(seed);
         a = seed[7:0];
         b = seed[15:8];
         k = t % 12;
         case (t)
            0: begin a = 8'hff; b = 8'h01; end
            1: begin a = 8'h00; b = 8'h00; end
            7: begin a = 8'h0f; b = 8'h01; end
            8: begin a = 8'h10; b = 8'h01; end
            default: ;
         endcase
         f = alu(k, a, b, c, dc);
         c = f[10];
         dc = f[9];
         put(14'h3000 | a); put(14'h00a0); put(14'h3000 | b);
         put({2'b00, OPC[k], 8'h20}); put(14'h00a1); put(14'h0803); put(14'h00a2);
         want({8'h20, a}); want({8'h21, f[7:0]}); want({8'h22, 5'b00011, f[8], f[9], f[10]});
      end
      // literal subtract with borrow, skip on clear carry, then bit set on memory
      f = alu(1, 8'h03, 8'h05, 1'b0, 1'b0);
      put(14'h3005); put(14'h3c03); put(14'h00a5); put(14'h1803);
      put(14'h00a6); put(14'h00a7); put(14'h1425);
      want({8'h25, f[7:0]}); want({8'h27, f[7:0]}); want({8'h25, f[7:0] | 8'h01});
      put(14'h3077); put(14'h2800 | 14'(p + 2)); put(14'h00a3); put(14'h00a4);
      put(14'h2800 | 14'(p));
      want(16'h2477);
   endtask
   task run_wait;
      int i;
      for (i = 0; i < 4000 && wi < n; i++) @(posedge sys_clk);
      chk("write count", 16'(wi), 16'(n));
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      if (data_wr_en === 1'b1) begin
         chk("data write", {data_addr, data_wdata}, exp_a[wi]);
         wi++;
      end
   end
   initial begin
      rst_n = 1'b0;
      master_clear_n = 1'b1;
      seed = 32'd23;
      {c, dc, n, p, wi, error_cnt, tests_run} = '0;
      build;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      run_wait;
      // second pass after a master clear must repeat the same writes
      master_clear_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      wi = 0;
      master_clear_n <= 1'b1;
      run_wait;
      repeat (20) @(posedge sys_clk);
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      stop_test;
   end
endmodule // testbench
`default_nettype wire
